// ==== core/pmbpt_avg.v ====
`timescale 1ns/1ps
// sixteen-sample averager, one per telemetry channel
module pmbpt_avg #(
	parameter W = 16
) (
	// clock and control
	input  wire                clk,
	input  wire                rst,
	input  wire                ce,
	// sample side
	input  wire                strobe,
	input  wire signed [W-1:0] din,
	// result side
	output reg  signed [W-1:0] avg,
	output reg                 done
);
	reg signed [W+3:0] sum;  // running sum of up to 15 samples
	reg        [3:0]   cnt;  // samples taken in this set
	wire signed [W+3:0] next_sum = sum + {{4{din[W-1]}}, din};

	// accumulate, then hand over the mean once per set of sixteen
	always @(posedge clk) begin
		if (rst) begin
			sum  <= {(W+4){1'b0}};
			cnt  <= 4'h0;
			avg  <= {W{1'b0}};
			done <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (strobe) begin
				cnt <= cnt + 4'h1;
				if (cnt == 4'hf) begin  // sixteenth sample closes the set
					avg  <= next_sum[W+3:4];
					done <= 1'b1;
					sum  <= {(W+4){1'b0}};
				end else begin
					sum <= next_sum;
				end
			end
		end
	end
endmodule // pmbpt_avg

// ==== core/pmbpt_regs.vh ====
`ifndef PMBPT_REGS_VH
`define PMBPT_REGS_VH
// command codes of the decoded command port
`define PMBPT_CMD_OV_LIMIT   8'h01
`define PMBPT_CMD_UV_LIMIT   8'h02
`define PMBPT_CMD_OV_RESP    8'h03
`define PMBPT_CMD_UV_RESP    8'h04
`define PMBPT_CMD_INPUT_TURN_ON_THRESHOLD     8'h05
`define PMBPT_CMD_INPUT_TURN_OFF_THRESHOLD    8'h06
`define PMBPT_CMD_PG_ON      8'h07
`define PMBPT_CMD_PG_OFF     8'h08
`define PMBPT_CMD_I_GAIN     8'h09
`define PMBPT_CMD_I_OFS      8'h0a
`define PMBPT_CMD_READ_I     8'h0b
`define PMBPT_CMD_READ_VO    8'h0c
`define PMBPT_CMD_VO_OFS     8'h0d
`define PMBPT_CMD_VO_GAIN    8'h0e
`define PMBPT_CMD_READ_VI    8'h0f
`define PMBPT_CMD_VI_OFS     8'h10
`define PMBPT_CMD_VI_GAIN    8'h11
`define PMBPT_CMD_SCALE      8'h12
`define PMBPT_CMD_STORE_ALL  8'h13
// fixed linear-format exponents, five bits two's complement
`define PMBPT_EXP_M2         5'h1e
`define PMBPT_EXP_M4         5'h1c
`define PMBPT_EXP_M5         5'h1b
`define PMBPT_EXP_M8         5'h18
`define PMBPT_EXP_M9         5'h17
`define PMBPT_EXP_M15        5'h11
// reset values
`define PMBPT_RST_OV_IDX     2'h2
`define PMBPT_RST_UV_IDX     2'h2
`define PMBPT_RST_PG_ON      15'h046a
`define PMBPT_RST_PG_OFF     15'h0452
`define PMBPT_RST_SCALE      11'h100
`define PMBPT_RST_INPUT_TURN_ON_THRESHOLD     11'h00c
`define PMBPT_RST_INPUT_TURN_OFF_THRESHOLD    11'h00a
// input threshold limits, quarter-volt units
`define PMBPT_INPUT_TURN_ON_THRESHOLD_LOW     11'h00b
`define PMBPT_INPUT_TURN_OFF_THRESHOLD_LOW    11'h00a
`define PMBPT_VIN_HIGH       11'h038
// response field values
`define PMBPT_RESP_IGNORE    2'h0
`define PMBPT_RESP_DELAY     2'h1
`define PMBPT_RESP_SHUT      2'h2
`define PMBPT_RESP_FOLLOW    2'h3
`define PMBPT_RETRY_ALWAYS   3'h7
`define PMBPT_DELAY_CYCLES   3'h4
// timing
`define PMBPT_CLK_NS         20
`define PMBPT_AVG_PERIOD_NS  200000
`define PMBPT_AVG_SAMPLES    16
`endif

// ==== core/pmbpt_resp.v ====
`timescale 1ns/1ps
`include "pmbpt_regs.vh"
// per-fault response policy: ignore, delayed, immediate or follow
module pmbpt_resp #(
	parameter RETRY_CYC = 16
) (
	// clock and control
	input  wire       clk,
	input  wire       rst,
	input  wire       ce,
	// policy and events
	input  wire [7:0] resp,
	input  wire       clr,
	input  wire       fault,
	input  wire       sw_tick,
	// results
	output reg        off,
	output reg        flag
);
	localparam ST_RUN  = 4'b0001;  // output running
	localparam ST_WAIT = 4'b0010;  // counting switching cycles
	localparam ST_OFF  = 4'b0100;  // shut down
	localparam ST_RTRY = 4'b1000;  // pause before a restart
	reg [3:0]  state;
	reg [2:0]  cyc;    // switching cycles seen with the fault present
	reg [15:0] tmo;    // restart pause
	wire [1:0] mode  = resp[7:6];
	wire       retry = resp[5:3] == `PMBPT_RETRY_ALWAYS;

	// policy machine; a latched shutdown with no restart leaves
	// only through reset or a fresh write of the response byte
	always @(posedge clk) begin
		if (rst) begin
			state <= ST_RUN;
			cyc   <= 3'h0;
			tmo   <= 16'h0000;
			off   <= 1'b0;
			flag  <= 1'b0;
		end else if (ce) begin
			if (fault && mode != `PMBPT_RESP_IGNORE)
				flag <= 1'b1;
			else if (clr)
				flag <= 1'b0;
			case (state)
			ST_RUN: begin
				cyc <= 3'h0;
				off <= 1'b0;
				if (fault) begin
					case (mode)
					`PMBPT_RESP_DELAY: state <= ST_WAIT;
					`PMBPT_RESP_SHUT: begin
						state <= ST_OFF;
						off   <= 1'b1;
					end
					`PMBPT_RESP_FOLLOW: off <= 1'b1;
					default: off <= 1'b0;
					endcase
				end
			end
			ST_WAIT: begin
				if (!fault || clr) begin
					state <= ST_RUN;
				end else if (sw_tick) begin
					cyc <= cyc + 3'h1;
					// fourth switching cycle still faulted: stop
					if (cyc == `PMBPT_DELAY_CYCLES - 3'h1) begin
						state <= ST_OFF;
						off   <= 1'b1;
					end
				end
			end
			ST_OFF: begin
				off <= 1'b1;
				tmo <= RETRY_CYC[15:0];
				if (clr)
					state <= ST_RUN;
				else if (retry)
					state <= ST_RTRY;
			end
			ST_RTRY: begin
				// hiccup: pause, then try again whatever the fault
				if (tmo == 16'h0000 || clr)
					state <= ST_RUN;
				else
					tmo <= tmo - 16'h0001;
			end
			default: state <= ST_RUN;
			endcase
		end
	end
endmodule // pmbpt_resp

// ==== core/pmbpt_top.v ====
`timescale 1ns/1ps
`include "pmbpt_regs.vh"
// Behaviour
// - over-voltage 108/110/112/115 percent, default 112
// - under-voltage 92/90/88/85 percent, default 88
// - fault limits linear, exponent -10, divider scaled
// - round in-range limit to nearest percentage
// - response 00 keeps running regardless
// - response 01 four cycles then shut down
// - response 10 immediate shut down, optional restart
// - response 11 follows the fault level
// - input on/off threshold allowed value sets
// - other input thresholds mapped to closest
// - input thresholds exponent -2, top mantissa zero
// - power-good low on faults or regulation loss
// - symmetric power-good windows from lower levels
// - power-good levels exponent -10, bit 15 zero
// - power-good defaults, saved by store-all
// - sixteen-sample averages every 200 us
// - current gain factor, exponent -15
// - current offset exponent -4, host accessible
// - current reading exponent -4, zero when sinking
// - output voltage reading all mantissa, -10
// - output voltage gain and offset correction
// - input voltage reading and correction, -5
// - divider ratio exponent -9, 11-bit mantissa
module pmbpt_top #(
	parameter AVG_PERIOD_CYC = `PMBPT_AVG_PERIOD_NS / `PMBPT_CLK_NS,
	parameter RETRY_CYC      = 1000,
	parameter I_GAIN_RST     = 11'h100,  // factory gain stand-in
	parameter I_SHIFT        = 31        // sense lsb 2^-20 V to 2^-4 A
) (
	// clock, reset, enable
	input  wire        clk,
	input  wire        rst,
	input  wire        ce,
	// decoded command port
	input  wire [7:0]  cmd_code,
	input  wire        cmd_wr,
	input  wire        cmd_rd,
	input  wire [15:0] cmd_wdata,
	output reg  [15:0] cmd_rdata,
	output reg         cmd_ack,
	output reg         cmd_err,
	output reg         store_all_req,
	// converter sense inputs
	input  wire [15:0] vout_cmd,     // commanded output, lsb 2^-10 V
	input  wire [15:0] vfb_sense,    // feedback node, lsb 2^-10 V
	input  wire [15:0] iout_sense,   // inductor voltage, lsb 2^-20 V
	input  wire [15:0] vout_sense,   // output, lsb 2^-10 V
	input  wire [15:0] vin_sense,    // input, lsb 2^-5 V
	input  wire        sw_tick,
	input  wire        ot_fault,
	input  wire        oc_fault,
	// converter control and power-good pin
	output reg         output_enable,
	output reg         ov_fault_flag,
	output reg         uv_fault_flag,
	output reg         power_ok_output_out,
	output reg         power_ok_output_oe_n
);
	localparam SAMPLE_CYC = AVG_PERIOD_CYC / `PMBPT_AVG_SAMPLES;

	// host-visible settings
	reg [15:0] ov_limit, uv_limit;   // last written raw limits
	reg [1:0]  ov_idx, uv_idx;       // rounded percentage choice
	reg [7:0]  ov_resp, uv_resp;
	reg [10:0] input_turn_on_threshold, input_turn_off_threshold;      // quarter-volt units
	reg [14:0] pg_on, pg_off;        // lsb 2^-10 V
	reg [10:0] scale;                // divider ratio, lsb 2^-9
	reg [10:0] i_gain, i_ofs, vo_gain, vi_gain, vi_ofs;
	reg [15:0] vo_ofs;
	// telemetry readings, refreshed only at averaging updates
	reg [9:0]  rd_i, rd_vi;
	reg [15:0] rd_vo;
	// status
	reg        vin_ok, pg_good;
	reg [15:0] smp_cnt;
	reg        smp_stb;

	wire wr = ce && cmd_wr;
	wire ov_off, uv_off, ov_flag_w, uv_flag_w;
	wire signed [15:0] avg_i, avg_vo, avg_vi;
	wire done_i, done_vo, done_vi;

	// scale an output-side level to the feedback node
	function [15:0] to_fb;
		input [15:0] v;
		reg   [26:0] p;
		begin
			p     = v * scale;
			to_fb = p[24:9];
		end
	endfunction

	// nearest percentage, compared at twice the percent scale
	wire [31:0] lim200 = {16'h0000, cmd_wdata} * 32'd200;
	wire [31:0] cmd1   = {16'h0000, vout_cmd};
	reg  [1:0]  ov_near, uv_near;
	always @* begin
		if (lim200 < cmd1 * 32'd218)      ov_near = 2'h0;
		else if (lim200 < cmd1 * 32'd222) ov_near = 2'h1;
		else if (lim200 < cmd1 * 32'd227) ov_near = 2'h2;
		else                              ov_near = 2'h3;
		if (lim200 > cmd1 * 32'd182)      uv_near = 2'h0;
		else if (lim200 > cmd1 * 32'd178) uv_near = 2'h1;
		else if (lim200 > cmd1 * 32'd173) uv_near = 2'h2;
		else                              uv_near = 2'h3;
	end

	// closest allowed input threshold; odd quarter steps round up
	function [10:0] vin_map;
		input [10:0] m;
		input [10:0] low;
		begin
			if (m <= low)
				vin_map = low;
			else if (m >= `PMBPT_VIN_HIGH)
				vin_map = `PMBPT_VIN_HIGH;
			else if (m[0])
				vin_map = m + 11'h001;
			else
				vin_map = m;
		end
	endfunction

	// register writes through the command port
	always @(posedge clk) begin
		if (rst) begin
			ov_limit <= 16'h0000;
			uv_limit <= 16'h0000;
			ov_idx   <= `PMBPT_RST_OV_IDX;
			uv_idx   <= `PMBPT_RST_UV_IDX;
			ov_resp  <= 8'h00;
			uv_resp  <= 8'h00;
			input_turn_on_threshold   <= `PMBPT_RST_INPUT_TURN_ON_THRESHOLD;
			input_turn_off_threshold  <= `PMBPT_RST_INPUT_TURN_OFF_THRESHOLD;
			pg_on    <= `PMBPT_RST_PG_ON;
			pg_off   <= `PMBPT_RST_PG_OFF;
			scale    <= `PMBPT_RST_SCALE;
			i_gain   <= I_GAIN_RST;
			i_ofs    <= 11'h000;
			vo_gain  <= 11'h000;
			vo_ofs   <= 16'h0000;
			vi_gain  <= 11'h000;
			vi_ofs   <= 11'h000;
		end else if (wr) begin
			case (cmd_code)
			`PMBPT_CMD_OV_LIMIT: begin
				ov_limit <= cmd_wdata;
				ov_idx   <= ov_near;
			end
			`PMBPT_CMD_UV_LIMIT: begin
				uv_limit <= cmd_wdata;
				uv_idx   <= uv_near;
			end
			`PMBPT_CMD_OV_RESP: ov_resp <= cmd_wdata[7:0];
			`PMBPT_CMD_UV_RESP: uv_resp <= cmd_wdata[7:0];
			// exponent field ignored, it is fixed
			`PMBPT_CMD_INPUT_TURN_ON_THRESHOLD:
				input_turn_on_threshold <= vin_map(cmd_wdata[10:0], `PMBPT_INPUT_TURN_ON_THRESHOLD_LOW);
			`PMBPT_CMD_INPUT_TURN_OFF_THRESHOLD:
				input_turn_off_threshold <= vin_map(cmd_wdata[10:0], `PMBPT_INPUT_TURN_OFF_THRESHOLD_LOW);
			`PMBPT_CMD_PG_ON:   pg_on   <= cmd_wdata[14:0];
			`PMBPT_CMD_PG_OFF:  pg_off  <= cmd_wdata[14:0];
			`PMBPT_CMD_I_GAIN:  i_gain  <= cmd_wdata[10:0];
			`PMBPT_CMD_I_OFS:   i_ofs   <= cmd_wdata[10:0];
			`PMBPT_CMD_VO_GAIN: vo_gain <= cmd_wdata[10:0];
			`PMBPT_CMD_VO_OFS:  vo_ofs  <= cmd_wdata;
			`PMBPT_CMD_VI_GAIN: vi_gain <= cmd_wdata[10:0];
			`PMBPT_CMD_VI_OFS:  vi_ofs  <= cmd_wdata[10:0];
			`PMBPT_CMD_SCALE:   scale   <= cmd_wdata[10:0];
			default: ;
			endcase
		end
	end

	// read mux; fixed exponents are reinserted on the way out
	reg [15:0] rmux;
	reg        rhit;
	always @* begin
		rhit = 1'b1;
		case (cmd_code)
		`PMBPT_CMD_OV_LIMIT: rmux = ov_limit;
		`PMBPT_CMD_UV_LIMIT: rmux = uv_limit;
		`PMBPT_CMD_OV_RESP:  rmux = {8'h00, ov_resp};
		`PMBPT_CMD_UV_RESP:  rmux = {8'h00, uv_resp};
		`PMBPT_CMD_INPUT_TURN_ON_THRESHOLD:   rmux = {`PMBPT_EXP_M2, input_turn_on_threshold};
		`PMBPT_CMD_INPUT_TURN_OFF_THRESHOLD:  rmux = {`PMBPT_EXP_M2, input_turn_off_threshold};
		`PMBPT_CMD_PG_ON:    rmux = {1'b0, pg_on};
		`PMBPT_CMD_PG_OFF:   rmux = {1'b0, pg_off};
		`PMBPT_CMD_I_GAIN:   rmux = {`PMBPT_EXP_M15, i_gain};
		`PMBPT_CMD_I_OFS:    rmux = {`PMBPT_EXP_M4, i_ofs};
		`PMBPT_CMD_READ_I:   rmux = {`PMBPT_EXP_M4, 1'b0, rd_i};
		`PMBPT_CMD_READ_VO:  rmux = rd_vo;
		`PMBPT_CMD_VO_OFS:   rmux = vo_ofs;
		`PMBPT_CMD_VO_GAIN:  rmux = {`PMBPT_EXP_M8, vo_gain};
		`PMBPT_CMD_READ_VI:  rmux = {`PMBPT_EXP_M5, 1'b0, rd_vi};
		`PMBPT_CMD_VI_OFS:   rmux = {`PMBPT_EXP_M5, vi_ofs};
		`PMBPT_CMD_VI_GAIN:  rmux = {`PMBPT_EXP_M8, vi_gain};
		`PMBPT_CMD_SCALE:    rmux = {`PMBPT_EXP_M9, scale};
		default: begin
			rmux = 16'h0000;
			rhit = cmd_code == `PMBPT_CMD_STORE_ALL && cmd_wr;
		end
		endcase
	end

	// command answer, one cycle after the request
	always @(posedge clk) begin
		if (rst) begin
			cmd_rdata     <= 16'h0000;
			cmd_ack       <= 1'b0;
			cmd_err       <= 1'b0;
			store_all_req <= 1'b0;
		end else if (ce) begin
			cmd_ack       <= cmd_wr || cmd_rd;
			cmd_err       <= (cmd_wr || cmd_rd) && !rhit;
			store_all_req <= cmd_wr && cmd_code == `PMBPT_CMD_STORE_ALL;
			if (cmd_rd)
				cmd_rdata <= rmux;
		end
	end

	// sample strobe: sixteen per averaging period
	always @(posedge clk) begin
		if (rst) begin
			smp_cnt <= 16'h0000;
			smp_stb <= 1'b0;
		end else if (ce) begin
			smp_stb <= smp_cnt == 16'h0000;
			if (smp_cnt == 16'h0000)
				smp_cnt <= SAMPLE_CYC[15:0] - 16'h0001;
			else
				smp_cnt <= smp_cnt - 16'h0001;
		end
	end

	pmbpt_avg #(.W(16)) u_avg_i (
		.clk(clk), .rst(rst), .ce(ce), .strobe(smp_stb),
		.din(iout_sense), .avg(avg_i), .done(done_i)
	);
	pmbpt_avg #(.W(16)) u_avg_vo (
		.clk(clk), .rst(rst), .ce(ce), .strobe(smp_stb),
		.din(vout_sense), .avg(avg_vo), .done(done_vo)
	);
	pmbpt_avg #(.W(16)) u_avg_vi (
		.clk(clk), .rst(rst), .ce(ce), .strobe(smp_stb),
		.din(vin_sense), .avg(avg_vi), .done(done_vi)
	);

	// calibration arithmetic on the fresh averages
	wire signed [47:0] i_prod = avg_i * $signed(i_gain);
	// every term is signed, else the shifts turn logical
	wire signed [47:0] i_val  = (i_prod >>> I_SHIFT)
		+ $signed({{37{i_ofs[10]}}, i_ofs});
	wire signed [31:0] vo_prod = avg_vo * $signed({5'h00, 11'h100}
		+ {{5{vo_gain[10]}}, vo_gain});
	wire signed [31:0] vo_val = (vo_prod >>> 8)
		+ $signed({{16{vo_ofs[15]}}, vo_ofs});
	wire signed [31:0] vi_prod = avg_vi * $signed({5'h00, 11'h100}
		+ {{5{vi_gain[10]}}, vi_gain});
	wire signed [31:0] vi_val = (vi_prod >>> 8)
		+ $signed({{21{vi_ofs[10]}}, vi_ofs});

	// readings change only when a set completes, so both bytes of a
	// word always come from one set
	always @(posedge clk) begin
		if (rst) begin
			rd_i  <= 10'h000;
			rd_vo <= 16'h0000;
			rd_vi <= 10'h000;
		end else if (ce) begin
			if (done_i) begin
				if (i_val < 0)
					rd_i <= 10'h000;  // sinking reads zero
				else if (i_val > 48'sd1023)
					rd_i <= 10'h3ff;
				else
					rd_i <= i_val[9:0];
			end
			if (done_vo)
				rd_vo <= vo_val[15:0];
			if (done_vi) begin
				if (vi_val < 0)
					rd_vi <= 10'h000;
				else if (vi_val > 32'sd1023)
					rd_vi <= 10'h3ff;
				else
					rd_vi <= vi_val[9:0];
			end
		end
	end

	// trip points in the feedback domain avoid any divider
	wire [15:0] nom_fb  = to_fb(vout_cmd);
	wire [15:0] on_fb   = to_fb({1'b0, pg_on});
	wire [15:0] off_fb  = to_fb({1'b0, pg_off});
	wire [16:0] nom2    = {nom_fb, 1'b0};
	wire [16:0] on_hi   = nom2 - {1'b0, on_fb};
	wire [16:0] off_hi  = nom2 - {1'b0, off_fb};
	wire [23:0] fb100   = vfb_sense * 8'd100;
	reg  [7:0]  ov_pct, uv_pct;
	always @* begin
		case (ov_idx)
		2'h0:    ov_pct = 8'd108;
		2'h1:    ov_pct = 8'd110;
		2'h2:    ov_pct = 8'd112;
		default: ov_pct = 8'd115;
		endcase
		case (uv_idx)
		2'h0:    uv_pct = 8'd92;
		2'h1:    uv_pct = 8'd90;
		2'h2:    uv_pct = 8'd88;
		default: uv_pct = 8'd85;
		endcase
	end
	wire ov_now = fb100 > nom_fb * ov_pct;
	wire uv_now = fb100 < nom_fb * uv_pct;

	pmbpt_resp #(.RETRY_CYC(RETRY_CYC)) u_resp_ov (
		.clk(clk), .rst(rst), .ce(ce), .resp(ov_resp),
		.clr(wr && cmd_code == `PMBPT_CMD_OV_RESP),
		.fault(ov_now), .sw_tick(sw_tick),
		.off(ov_off), .flag(ov_flag_w)
	);
	pmbpt_resp #(.RETRY_CYC(RETRY_CYC)) u_resp_uv (
		.clk(clk), .rst(rst), .ce(ce), .resp(uv_resp),
		.clr(wr && cmd_code == `PMBPT_CMD_UV_RESP),
		.fault(uv_now), .sw_tick(sw_tick),
		.off(uv_off), .flag(uv_flag_w)
	);

	// input lockout with hysteresis on the averaged input voltage;
	// both sides of each compare are in 2^-10 V steps
	always @(posedge clk) begin
		if (rst) begin
			vin_ok        <= 1'b0;
			output_enable <= 1'b0;
			ov_fault_flag <= 1'b0;
			uv_fault_flag <= 1'b0;
		end else if (ce) begin
			if (!vin_ok && {rd_vi, 5'h00} >= {input_turn_on_threshold, 8'h00})
				vin_ok <= 1'b1;
			else if (vin_ok && {rd_vi, 5'h00} < {input_turn_off_threshold, 8'h00})
				vin_ok <= 1'b0;
			output_enable <= vin_ok && !ov_off && !uv_off;
			ov_fault_flag <= ov_flag_w;
			uv_fault_flag <= uv_flag_w;
		end
	end

	// power-good: assert inside the on window, drop outside the off
	// window or on any fault that would pull the output away
	wire pg_kill = ot_fault || oc_fault || !output_enable;
	wire in_on   = vfb_sense >= on_fb &&
		{1'b0, vfb_sense} <= on_hi;
	wire out_off = vfb_sense < off_fb || {1'b0, vfb_sense} > off_hi;
	always @(posedge clk) begin
		if (rst) begin
			pg_good              <= 1'b0;
			power_ok_output_out  <= 1'b0;
			power_ok_output_oe_n <= 1'b0;
		end else if (ce) begin
			if (pg_kill || out_off)
				pg_good <= 1'b0;
			else if (in_on)
				pg_good <= 1'b1;
			// open drain: pull low while not good, release otherwise
			power_ok_output_out  <= 1'b0;
			power_ok_output_oe_n <= pg_good && !pg_kill && !out_off;
		end
	end
endmodule // pmbpt_top

// ==== dv/pmbpt_chk.sv ====
`timescale 1ns/1ps
`include "pmbpt_regs.vh"
// port-level watcher of the supervision block
module pmbpt_chk (
	// clock and reset
	input wire       clk,
	input wire       rst,
	input wire       ce,
	// command port
	input wire [7:0] cmd_code,
	input wire       cmd_wr,
	input wire       cmd_rd,
	input wire       cmd_ack,
	input wire       cmd_err,
	input wire       store_all_req,
	// converter side
	input wire       ot_fault,
	input wire       oc_fault,
	input wire       output_enable,
	input wire       power_ok_output_out,
	input wire       power_ok_output_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire req = ce && (cmd_wr || cmd_rd);              // request taken
	// nothing behind it; store-all is a write-only code
	wire bad = cmd_code == 8'h00 || cmd_code > 8'h13 ||
		(cmd_code == `PMBPT_CMD_STORE_ALL && cmd_rd);
	wire sto = ce && cmd_wr && cmd_code == `PMBPT_CMD_STORE_ALL;
	ack_on_req_a: assert property (req |=> cmd_ack)
		else $error("no acknowledge after request");
	ack_cause_a: assert property (cmd_ack |-> $past(req))
		else $error("acknowledge without request");
	err_unmapped_a: assert property (req && bad |=> cmd_err && cmd_ack)
		else $error("unmapped code not refused");
	err_mapped_a: assert property (req && !bad |=> !cmd_err)
		else $error("mapped code refused");
	store_pulse_a: assert property (sto |=> store_all_req)
		else $error("store request missing");
	store_cause_a: assert property (store_all_req |-> $past(sto))
		else $error("store request without write");
	// the pin path is registered once, four cycles is a safe margin
	pg_fault_low_a: assert property ((ot_fault || oc_fault)[*4]
		|-> !power_ok_output_oe_n) else $error("power ok kept on fault");
	pg_off_low_a: assert property ((!output_enable)[*4]
		|-> !power_ok_output_oe_n) else $error("power ok while stopped");
	pg_drive_zero_a: assert property (!power_ok_output_out)
		else $error("open drain drives high");
	reset_state_a: assert property ($fell(rst) |-> !output_enable
		&& !power_ok_output_oe_n) else $error("outputs not cleared");
	cover property (req && bad ##1 cmd_err);
	cover property ($fell(output_enable));
	cover property ($rose(output_enable));
	cover property (store_all_req);
endmodule // pmbpt_chk

bind pmbpt_top pmbpt_chk pmbpt_chk_i (
	.clk(clk), .rst(rst), .ce(ce), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
	.cmd_rd(cmd_rd), .cmd_ack(cmd_ack), .cmd_err(cmd_err),
	.store_all_req(store_all_req), .ot_fault(ot_fault),
	.oc_fault(oc_fault), .output_enable(output_enable),
	.power_ok_output_out(power_ok_output_out),
	.power_ok_output_oe_n(power_ok_output_oe_n));

// ==== dv/pmbpt_host.sv ====
`timescale 1ns/1ps
// host controller model on the decoded command port
module pmbpt_host (
	// clock
	input  wire         clk,
	// command port
	output logic [7:0]  cmd_code,
	output logic        cmd_wr,
	output logic        cmd_rd,
	output logic [15:0] cmd_wdata,
	input  wire  [15:0] cmd_rdata,
	input  wire         cmd_ack,
	input  wire         cmd_err
);
	logic [15:0] last_rdata; // word taken at the acknowledging edge
	logic        last_err;   // refusal flag taken with it
	logic        last_ack;   // acknowledge seen within the limit
	initial begin
		cmd_code = 8'h00;
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_wdata = 16'h0000;
	end
	// strobe is a one-cycle pulse; code stays until the acknowledge
	task xfer(input logic wr, input logic [7:0] c, input logic [15:0] w);
		int n;
		@(posedge clk);
		#1;
		cmd_code = c;
		cmd_wr = wr;
		cmd_rd = !wr;
		cmd_wdata = w;
		@(posedge clk);
		#1;
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		n = 0;
		// bounded so a silent design cannot hang the run
		while (cmd_ack !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		last_ack = cmd_ack;
		last_rdata = cmd_rdata;
		last_err = cmd_err;
		// released data shows a changed pattern, not the old word
		cmd_wdata = ~w;
	endtask
endmodule // pmbpt_host

// ==== dv/pmbpt_top_tb.sv ====
`timescale 1ns/1ps
`include "pmbpt_regs.vh"
// self-checking bench of the supervision block
module pmbpt_top_tb;
	logic        clk, rst, ce;            // clock, reset, enable
	wire  [7:0]  cmd_code;                // command port from the host
	wire         cmd_wr, cmd_rd;
	wire  [15:0] cmd_wdata, cmd_rdata;
	wire         cmd_ack, cmd_err, store_all_req;
	logic [15:0] vout_cmd, vfb_sense;     // regulation inputs
	logic [15:0] iout_sense, vout_sense;  // telemetry inputs
	logic [15:0] vin_sense;
	logic        sw_tick, ot_fault, oc_fault;
	wire         output_enable, ov_fault_flag, uv_fault_flag;
	wire         power_ok_output_out, power_ok_output_oe_n;
	int          err_count, n_compared, cycles;
	// short averaging period and retry keep the run small
	pmbpt_top #(.AVG_PERIOD_CYC(160), .RETRY_CYC(8), .I_GAIN_RST(11'h100),
		.I_SHIFT(31)) pmbpt_top_i (.clk(clk), .rst(rst), .ce(ce),
		.cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
		.cmd_err(cmd_err), .store_all_req(store_all_req),
		.vout_cmd(vout_cmd), .vfb_sense(vfb_sense), .iout_sense(iout_sense),
		.vout_sense(vout_sense), .vin_sense(vin_sense), .sw_tick(sw_tick),
		.ot_fault(ot_fault), .oc_fault(oc_fault),
		.output_enable(output_enable), .ov_fault_flag(ov_fault_flag),
		.uv_fault_flag(uv_fault_flag),
		.power_ok_output_out(power_ok_output_out),
		.power_ok_output_oe_n(power_ok_output_oe_n));
	pmbpt_host pmbpt_host_i (.clk(clk), .cmd_code(cmd_code),
		.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
		.cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_err(cmd_err));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// cycle ceiling far above the planned run length
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_count++;
			end_of_test;
		end
	end
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [7:0] c, input logic [15:0] w);
		pmbpt_host_i.xfer(1'b1, c, w);
		check("ack", pmbpt_host_i.last_ack, 1'b1);
	endtask
	task rd(input string what, input logic [7:0] c, input logic [15:0] exp);
		pmbpt_host_i.xfer(1'b0, c, 16'h0000);
		check("ack", pmbpt_host_i.last_ack, 1'b1);
		check(what, pmbpt_host_i.last_rdata, exp);
	endtask
	task ticks(input int n);
		repeat (n) begin
			sw_tick = 1'b1;
			cyc(1);
			sw_tick = 1'b0;
			cyc(1);
		end
	endtask
	// fault level on the feedback node, then settle and look at enable
	task fb(input logic [15:0] v, input int n, input logic exp);
		vfb_sense = v;
		cyc(n);
		check("enable", output_enable, exp);
	endtask
	task t_defaults;
		rd("pg on", `PMBPT_CMD_PG_ON, 16'h046a);
		rd("pg off", `PMBPT_CMD_PG_OFF, 16'h0452);
		rd("input_turn_on_threshold", `PMBPT_CMD_INPUT_TURN_ON_THRESHOLD, 16'hf00c);
		rd("scale", `PMBPT_CMD_SCALE, 16'hb900);
		rd("i gain", `PMBPT_CMD_I_GAIN, 16'h8900);
		rd("unmapped", 8'h20, 16'h0000);
		check("unmapped err", pmbpt_host_i.last_err, 1'b1);
		wr(`PMBPT_CMD_READ_VO, 16'h1234);
		check("ro err", pmbpt_host_i.last_err, 1'b0);
		wr(`PMBPT_CMD_STORE_ALL, 16'h0000);
		$display("t_defaults done");
	endtask
	// out-of-set thresholds snap to the nearest legal quarter step
	task t_thresholds;
		wr(`PMBPT_CMD_INPUT_TURN_ON_THRESHOLD, 16'hf00a);
		rd("input_turn_on_threshold low", `PMBPT_CMD_INPUT_TURN_ON_THRESHOLD, 16'hf00b);
		wr(`PMBPT_CMD_INPUT_TURN_ON_THRESHOLD, 16'hf00d);
		rd("input_turn_on_threshold mid", `PMBPT_CMD_INPUT_TURN_ON_THRESHOLD, 16'hf00e);
		wr(`PMBPT_CMD_INPUT_TURN_ON_THRESHOLD, 16'hf040);
		rd("input_turn_on_threshold high", `PMBPT_CMD_INPUT_TURN_ON_THRESHOLD, 16'hf038);
		wr(`PMBPT_CMD_INPUT_TURN_OFF_THRESHOLD, 16'hf009);
		rd("input_turn_off_threshold low", `PMBPT_CMD_INPUT_TURN_OFF_THRESHOLD, 16'hf00a);
		wr(`PMBPT_CMD_INPUT_TURN_OFF_THRESHOLD, 16'hf00b);
		rd("input_turn_off_threshold mid", `PMBPT_CMD_INPUT_TURN_OFF_THRESHOLD, 16'hf00c);
		wr(`PMBPT_CMD_INPUT_TURN_ON_THRESHOLD, 16'hf00c);
		wr(`PMBPT_CMD_INPUT_TURN_OFF_THRESHOLD, 16'hf00a);
		wr(`PMBPT_CMD_PG_ON, 16'hffff);
		rd("pg top bit", `PMBPT_CMD_PG_ON, 16'h7fff);
		wr(`PMBPT_CMD_PG_ON, 16'h046a);
		wr(`PMBPT_CMD_I_OFS, 16'he010);
		rd("i offset", `PMBPT_CMD_I_OFS, 16'he010);
		wr(`PMBPT_CMD_I_OFS, 16'he000);
		$display("t_thresholds done");
	endtask
	task t_telemetry;
		cyc(360);
		rd("vout", `PMBPT_CMD_READ_VO, 16'h0400);
		rd("vin", `PMBPT_CMD_READ_VI, 16'hd980);
		rd("iout sink", `PMBPT_CMD_READ_I, 16'he000);
		wr(`PMBPT_CMD_VO_GAIN, 16'hc010);
		wr(`PMBPT_CMD_VO_OFS, 16'h0010);
		wr(`PMBPT_CMD_VI_OFS, 16'hd804);
		cyc(360);
		rd("vout cal", `PMBPT_CMD_READ_VO, 16'h0450);
		rd("vin cal", `PMBPT_CMD_READ_VI, 16'hd984);
		rd("vout gain", `PMBPT_CMD_VO_GAIN, 16'hc010);
		$display("t_telemetry done");
	endtask
	// 0x236 is over 110 but under 112 percent of a 0x200 nominal
	task t_response;
		wr(`PMBPT_CMD_SCALE, 16'hb900);
		wr(`PMBPT_CMD_OV_RESP, 16'h0080);
		fb(16'h0236, 10, 1'b1);
		wr(`PMBPT_CMD_OV_LIMIT, 16'h0460);
		cyc(5);
		check("enable", output_enable, 1'b0);
		check("ov flag", ov_fault_flag, 1'b1);
		fb(16'h0200, 20, 1'b0);
		wr(`PMBPT_CMD_OV_RESP, 16'h00b8);
		fb(16'h0236, 5, 1'b0);
		fb(16'h0200, 20, 1'b1);
		wr(`PMBPT_CMD_OV_RESP, 16'h0040);
		vfb_sense = 16'h0236;
		ticks(3);
		check("enable", output_enable, 1'b1);
		ticks(2);
		fb(16'h0236, 3, 1'b0);
		wr(`PMBPT_CMD_OV_RESP, 16'h00c0);
		fb(16'h0200, 5, 1'b1);
		// a low enable freezes the policy, so the output stays on
		ce = 1'b0;
		fb(16'h0236, 5, 1'b1);
		ce = 1'b1;
		fb(16'h0236, 5, 1'b0);
		fb(16'h0200, 5, 1'b1);
		wr(`PMBPT_CMD_OV_RESP, 16'h0038);
		fb(16'h0236, 10, 1'b1);
		check("ov flag", ov_fault_flag, 1'b0);
		wr(`PMBPT_CMD_UV_RESP, 16'h0080);
		fb(16'h01c8, 10, 1'b1);
		wr(`PMBPT_CMD_UV_LIMIT, 16'h0390);
		fb(16'h01c8, 5, 1'b0);
		check("uv flag", uv_fault_flag, 1'b1);
		// window below the 1 V nominal, so the pin can come up
		vfb_sense = 16'h0200;
		wr(`PMBPT_CMD_UV_RESP, 16'h0000);
		wr(`PMBPT_CMD_PG_ON, 16'h03a0);
		wr(`PMBPT_CMD_PG_OFF, 16'h0380);
		cyc(5);
		check("pg good", power_ok_output_oe_n, 1'b1);
		vfb_sense = 16'h0248;
		cyc(5);
		check("pg above", power_ok_output_oe_n, 1'b0);
		vfb_sense = 16'h0200;
		ot_fault = 1'b1;
		cyc(5);
		check("pg on ot", power_ok_output_oe_n, 1'b0);
		ot_fault = 1'b0;
		oc_fault = 1'b1;
		cyc(5);
		check("pg on oc", power_ok_output_oe_n, 1'b0);
		oc_fault = 1'b0;
		cyc(5);
		check("pg back", power_ok_output_oe_n, 1'b1);
		$display("t_response done");
	endtask
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		cycles = 0;
		err_count = 0;
		n_compared = 0;
		vout_cmd = 16'h0400;
		vfb_sense = 16'h0200;
		iout_sense = 16'hff9c;
		vout_sense = 16'h0400;
		vin_sense = 16'h0180;
		sw_tick = 1'b0;
		ot_fault = 1'b0;
		oc_fault = 1'b0;
		cyc(4);
		rst = 1'b0;
		t_defaults;
		t_thresholds;
		t_telemetry;
		t_response;
		end_of_test;
	end
endmodule // pmbpt_top_tb
